/* File: src/bus_sizer_regs.vh */
// register map, field positions, reset values and timing for the bus sizer
`ifndef BUS_SIZER_REGS_VH
`define BUS_SIZER_REGS_VH

// register indices; byte address on the bus is four times the index
`define IDX_AREA0_CTL 8'hC0
`define IDX_AREA1_CTL 8'hC1
`define IDX_AREA2_CTL 8'hC2
`define IDX_AREA3_CTL 8'hC3
`define IDX_FALLBACK_CTL 8'hC7
`define IDX_SIZER_STATUS 8'hC8

// fields of an area control register
`define F_MASTER_ENABLE 7
`define F_AREA2_RANGE_MODE 6
`define F_STROBE_SHAPE_HI 5
`define F_STROBE_SHAPE_LO 4
`define F_WIDTH_SELECT 3
`define F_WAIT_HI 2
`define F_WAIT_LO 0

// reset values
`define RST_AREA_CTL 8'h00
`define RST_AREA2_CTL 8'h80
`define RST_FALLBACK_CTL 4'h0

// strobe shape codes
`define SHAPE_ROM_SRAM 2'h0

// wait codes
`define WAIT_TWO 3'h0
`define WAIT_ONE 3'h1
`define WAIT_ONE_PLUS 3'h2
`define WAIT_NONE 3'h3
`define WAIT_RESERVED 3'h4
`define WAIT_THREE 3'h5
`define WAIT_FOUR 3'h6
`define WAIT_EIGHT 3'h7

// wait state counts per code
`define WAITS_TWO 4'h2
`define WAITS_ONE 4'h1
`define WAITS_THREE 4'h3
`define WAITS_FOUR 4'h4
`define WAITS_EIGHT 4'h8

// whole-space window of area two when its range mode is 0
`define AREA2_FULL_LO 24'h002000
`define AREA2_FULL_HI 24'hFDFFFF

// operand sizes on the core port
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2

`endif

/* File: src/wait_state_timer.v */
// wait state counter for one external bus cycle
`timescale 1ns/100ps
`include "bus_sizer_regs.vh"

module wait_state_timer (
   input wire clk_i,
   input wire rst_i,
   input wire start_i,
   input wire [2:0] code_i,
   input wire wait_n_i,
   output wire no_wait_o,
   output wire last_o,
   output wire [3:0] count_o
);

   reg [3:0] cnt_q;
   reg var_q;
   reg [3:0] load;

   // fixed codes ignore the wait pin; 1+N uses one state then the pin
   always @* begin
      case (code_i)
         `WAIT_TWO: load = `WAITS_TWO;
         `WAIT_ONE: load = `WAITS_ONE;
         `WAIT_ONE_PLUS: load = `WAITS_ONE;
         `WAIT_THREE: load = `WAITS_THREE;
         `WAIT_FOUR: load = `WAITS_FOUR;
         `WAIT_EIGHT: load = `WAITS_EIGHT;
         // reserved code 100 is treated as no wait; software must avoid it
         default: load = 4'h0;
      endcase
   end

   // code 011 skips the wait phase altogether
   assign no_wait_o = (load == 4'h0);

   // each cycle spent waiting burns one state; pin held low stretches
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 4'h0;
         var_q <= 1'b0;
      end else if (start_i) begin
         cnt_q <= load;
         var_q <= (code_i == `WAIT_ONE_PLUS);
      end else if (cnt_q > 4'h1) begin
         cnt_q <= cnt_q - 4'h1;
      end else if (last_o) begin
         cnt_q <= 4'h0;
      end
   end

   // final wait state; in 1+N mode only once the pin has gone high
   assign last_o = (cnt_q <= 4'h1) && (!var_q || wait_n_i);
   assign count_o = cnt_q;

endmodule

/* File: src/bus_sizer.v */
// chip select, wait control and dynamic bus sizing for external memory
//
// Functional notes
// - A strobe shape code of 00 gives the ROM/SRAM chip select timing; other codes change nothing.
// - With its range mode bit at 0 area two spans the whole space, with 1 it uses its own decode; reset clears the bit.
// - An area width bit of 0 selects a 16-bit external bus and 1 an 8-bit bus, for the fallback area too.
// - Accesses outside the four areas always use the fallback register's width and wait count.
// - Bit 7 of an area control register enables that area's settings when set.
// - Reset clears the enables of areas zero, one and three and sets the enable of area two.
// - Each core operand is split into as many external cycles as the area width needs.
// - 8-bit memory takes every byte on the low lane; 16-bit memory puts even bytes low and odd bytes high.
// - Idle lanes are ignored on reads, undriven on writes, and their write strobe stays off.
// - The wait field of the addressed area sets the wait states of every external cycle.
// - Reset loads every wait field with 000, giving two wait states.
// - Codes 000, 001, 101, 110 and 111 insert 2, 1, 3, 4 and 8 states regardless of the wait pin.
// - Code 011 ends the cycle with no wait state.
// - Code 010 inserts one state, then stretches while the active-low wait pin is low.
// - An access to internal I/O or RAM raises no external chip select.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/100ps
`include "bus_sizer_regs.vh"

module bus_sizer #(
   parameter ADDR_W = 24
) (
   input wire clk_i,
   input wire rst_i,
   // classic wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [9:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   // core operand port
   input wire cpu_req_i,
   input wire cpu_we_i,
   input wire [1:0] cpu_size_i,
   input wire [ADDR_W-1:0] cpu_addr_i,
   input wire [31:0] cpu_wdata_i,
   input wire [3:0] area_hit_i,
   input wire internal_hit_i,
   output wire cpu_ready_o,
   output wire cpu_ack_o,
   output wire [31:0] cpu_rdata_o,
   // external memory pins
   output wire [ADDR_W-1:0] mem_addr_o,
   output wire [3:0] mem_cs_n_o,
   output wire mem_rd_n_o,
   output wire [1:0] mem_wr_n_o,
   input wire [15:0] mem_d_i,
   output wire [15:0] mem_d_o,
   output wire [1:0] mem_d_oe_o,
   input wire mem_wait_n_i
);

   localparam ST_IDLE = 2'h0;
   localparam ST_T1 = 2'h1;
   localparam ST_TW = 2'h2;
   localparam ST_T2 = 2'h3;

   reg [7:0] area_ctl_q [0:3];
   reg [3:0] fb_ctl_q;
   reg wb_ack_q;
   reg [31:0] wb_dat_q;
   reg [31:0] rd_mux;
   reg [1:0] state_q;
   reg [ADDR_W-1:0] addr_q;
   reg [2:0] left_q;
   reg [1:0] done_q;
   reg we_q;
   reg [31:0] wdata_q;
   reg [31:0] rdata_q;
   reg wide_q;
   reg [2:0] wcode_q;
   reg [3:0] cs_sel_q;
   reg ack_q;
   reg [ADDR_W-1:0] mem_addr_q;
   reg [3:0] cs_n_q;
   reg rd_n_q;
   reg [1:0] wr_n_q;
   reg [15:0] dout_q;
   reg [1:0] oe_q;
   reg wait_meta_q;
   reg wait_sync_q;
   reg [3:0] hit;
   reg [2:0] area_idx;
   reg area_found;
   reg pick_wide;
   reg [2:0] pick_wait;
   reg [2:0] sz_bytes;
   reg two_bytes;
   integer i;
   integer j;

   wire wb_access = wb_cyc_i & wb_stb_i;
   wire [7:0] wb_idx = wb_adr_i[9:2];
   wire wt_no_wait;
   wire wt_last;
   wire [3:0] wt_count;
   wire beat_start = (state_q == ST_T1);

   // register reads; the area registers read back so software can
   // check its setup, unmapped words answer zero
   always @* begin
      case (wb_idx)
         `IDX_AREA0_CTL: rd_mux = {24'h000000, area_ctl_q[0]};
         `IDX_AREA1_CTL: rd_mux = {24'h000000, area_ctl_q[1]};
         `IDX_AREA2_CTL: rd_mux = {24'h000000, area_ctl_q[2]};
         `IDX_AREA3_CTL: rd_mux = {24'h000000, area_ctl_q[3]};
         `IDX_FALLBACK_CTL: rd_mux = {28'h0000000, fb_ctl_q};
         `IDX_SIZER_STATUS: rd_mux = {16'h0000, cs_sel_q, wt_count,
                                      1'b0, left_q, wide_q, wcode_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // wishbone answer one cycle after the request, dropped the next cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h00000000;
      end else begin
         wb_ack_q <= wb_access & ~wb_ack_q;
         wb_dat_q <= rd_mux;
      end
   end

   // control register writes land on the edge at which the master sees
   // ack, so an abandoned request never changes the setup
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (j = 0; j < 4; j = j + 1) begin
            area_ctl_q[j] <= `RST_AREA_CTL;
         end
         area_ctl_q[2] <= `RST_AREA2_CTL;
         fb_ctl_q <= `RST_FALLBACK_CTL;
      end else if (wb_access & wb_we_i & wb_sel_i[0] & wb_ack_q) begin
         case (wb_idx)
            `IDX_AREA0_CTL: area_ctl_q[0] <= wb_dat_i[7:0];
            `IDX_AREA1_CTL: area_ctl_q[1] <= wb_dat_i[7:0];
            `IDX_AREA2_CTL: area_ctl_q[2] <= wb_dat_i[7:0];
            `IDX_AREA3_CTL: area_ctl_q[3] <= wb_dat_i[7:0];
            `IDX_FALLBACK_CTL: fb_ctl_q <= wb_dat_i[3:0];
            default: fb_ctl_q <= fb_ctl_q;
         endcase
      end
   end

   // the wait pin is asynchronous, so it passes two flops first
   always @(posedge clk_i) begin
      if (rst_i) begin
         wait_meta_q <= 1'b1;
         wait_sync_q <= 1'b1;
      end else begin
         wait_meta_q <= mem_wait_n_i;
         wait_sync_q <= wait_meta_q;
      end
   end

   // area decode: enabled areas in index order, then the fallback;
   // the strobe shape field only has the ROM/SRAM timing, so other
   // codes select the same waveform
   always @* begin
      hit = area_hit_i;
      if (!area_ctl_q[2][`F_AREA2_RANGE_MODE]) begin
         hit[2] = (cpu_addr_i >= `AREA2_FULL_LO) &&
                  (cpu_addr_i <= `AREA2_FULL_HI);
      end
      area_found = 1'b0;
      area_idx = 3'h4;
      for (i = 3; i >= 0; i = i - 1) begin
         if (hit[i] && area_ctl_q[i][`F_MASTER_ENABLE]) begin
            area_found = 1'b1;
            area_idx = i[2:0];
         end
      end
      if (area_found) begin
         pick_wide = ~area_ctl_q[area_idx[1:0]][`F_WIDTH_SELECT];
         pick_wait = area_ctl_q[area_idx[1:0]][`F_WAIT_HI:`F_WAIT_LO];
      end else begin
         pick_wide = ~fb_ctl_q[`F_WIDTH_SELECT];
         pick_wait = fb_ctl_q[`F_WAIT_HI:`F_WAIT_LO];
      end
      case (cpu_size_i)
         `SIZE_BYTE: sz_bytes = 3'h1;
         `SIZE_WORD: sz_bytes = 3'h2;
         default: sz_bytes = 3'h4;
      endcase
   end

   // a beat carries two bytes only on 16-bit memory, even address and
   // at least two bytes left; odd starts open with a single byte
   always @* begin
      two_bytes = wide_q && !addr_q[0] && (left_q >= 3'h2);
   end

   // bus cycle sequencer: T1 address phase, TW waits, T2 data phase
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         addr_q <= {ADDR_W{1'b0}};
         left_q <= 3'h0;
         done_q <= 2'h0;
         we_q <= 1'b0;
         wdata_q <= 32'h00000000;
         rdata_q <= 32'h00000000;
         wide_q <= 1'b0;
         wcode_q <= 3'h0;
         cs_sel_q <= 4'h0;
         ack_q <= 1'b0;
      end else begin
         ack_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (cpu_req_i && internal_hit_i) begin
                  // internal targets answer at once, no external cycle
                  ack_q <= 1'b1;
                  rdata_q <= 32'h00000000;
                  cs_sel_q <= 4'h0;
               end else if (cpu_req_i) begin
                  addr_q <= cpu_addr_i;
                  left_q <= sz_bytes;
                  done_q <= 2'h0;
                  we_q <= cpu_we_i;
                  wdata_q <= cpu_wdata_i;
                  rdata_q <= 32'h00000000;
                  wide_q <= pick_wide;
                  wcode_q <= pick_wait;
                  cs_sel_q <= area_found ?
                              (4'h1 << area_idx[1:0]) : 4'h0;
                  state_q <= ST_T1;
               end
            end
            ST_T1: begin
               state_q <= wt_no_wait ? ST_T2 : ST_TW;
            end
            ST_TW: begin
               if (wt_last) begin
                  state_q <= ST_T2;
               end
            end
            ST_T2: begin
               // gather read bytes from the lane that carried them
               if (!we_q) begin
                  if (two_bytes) begin
                     rdata_q[done_q*8 +: 16] <= mem_d_i;
                  end else if (wide_q && addr_q[0]) begin
                     rdata_q[done_q*8 +: 8] <= mem_d_i[15:8];
                  end else begin
                     rdata_q[done_q*8 +: 8] <= mem_d_i[7:0];
                  end
               end
               if (two_bytes) begin
                  addr_q <= addr_q + {{(ADDR_W-2){1'b0}}, 2'h2};
                  done_q <= done_q + 2'h2;
                  left_q <= left_q - 3'h2;
               end else begin
                  addr_q <= addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
                  done_q <= done_q + 2'h1;
                  left_q <= left_q - 3'h1;
               end
               if ((two_bytes && left_q == 3'h2) || left_q == 3'h1) begin
                  ack_q <= 1'b1;
                  cs_sel_q <= 4'h0;
                  state_q <= ST_IDLE;
               end else begin
                  state_q <= ST_T1;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // pin drive registered from the current state, so strobes and lanes
   // change cleanly on the clock edge that closes each phase
   always @(posedge clk_i) begin
      if (rst_i) begin
         mem_addr_q <= {ADDR_W{1'b0}};
         cs_n_q <= 4'hF;
         rd_n_q <= 1'b1;
         wr_n_q <= 2'h3;
         dout_q <= 16'h0000;
         oe_q <= 2'h0;
      end else if (state_q == ST_T1 || state_q == ST_TW) begin
         // address, select and strobe hold through every wait state
         mem_addr_q <= addr_q;
         cs_n_q <= ~cs_sel_q;
         rd_n_q <= we_q;
         if (we_q) begin
            if (two_bytes) begin
               dout_q <= wdata_q[done_q*8 +: 16];
               oe_q <= 2'h3;
               wr_n_q <= 2'h0;
            end else if (wide_q && addr_q[0]) begin
               // odd byte rides the high lane; low lane left floating
               dout_q <= {wdata_q[done_q*8 +: 8], 8'h00};
               oe_q <= 2'h2;
               wr_n_q <= 2'h1;
            end else begin
               dout_q <= {8'h00, wdata_q[done_q*8 +: 8]};
               oe_q <= 2'h1;
               wr_n_q <= 2'h2;
            end
         end else begin
            oe_q <= 2'h0;
            wr_n_q <= 2'h3;
         end
      end else begin
         cs_n_q <= 4'hF;
         rd_n_q <= 1'b1;
         wr_n_q <= 2'h3;
         oe_q <= 2'h0;
      end
   end

   wait_state_timer u_wait (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(beat_start),
      .code_i(wcode_q),
      .wait_n_i(wait_sync_q),
      .no_wait_o(wt_no_wait),
      .last_o(wt_last),
      .count_o(wt_count)
   );

   assign wb_ack_o = wb_ack_q;
   assign wb_dat_o = wb_dat_q;
   assign cpu_ready_o = (state_q == ST_IDLE) & ~ack_q;
   assign cpu_ack_o = ack_q;
   assign cpu_rdata_o = rdata_q;
   assign mem_addr_o = mem_addr_q;
   assign mem_cs_n_o = cs_n_q;
   assign mem_rd_n_o = rd_n_q;
   assign mem_wr_n_o = wr_n_q;
   assign mem_d_o = dout_q;
   assign mem_d_oe_o = oe_q;

endmodule

/* File: bench/bus_sizer_chk.sv */
// pin level checks for the bus sizer
`timescale 1ns/100ps
module bus_sizer_chk #(
   parameter ADDR_W = 24
) (
   input wire clk_i,
   input wire rst_i,
   input wire cpu_req_i,
   input wire internal_hit_i,
   input wire cpu_ready_o,
   input wire cpu_ack_o,
   input wire [ADDR_W-1:0] mem_addr_o,
   input wire [3:0] mem_cs_n_o,
   input wire mem_rd_n_o,
   input wire [1:0] mem_wr_n_o,
   input wire [1:0] mem_d_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_internal_no_cs: assert property (
      cpu_req_i && cpu_ready_o && internal_hit_i |=>
      cpu_ack_o && mem_cs_n_o == 4'hF ##1 mem_cs_n_o == 4'hF)
      else $error("chip select on internal access");
   a_cs_one_area: assert property ($onehot0(~mem_cs_n_o))
      else $error("two chip selects low");
   a_cs_with_strobe: assert property (
      mem_cs_n_o != 4'hF |-> !mem_rd_n_o || mem_wr_n_o != 2'h3)
      else $error("chip select low without strobe");
   a_idle_lane_off: assert property (
      (~mem_wr_n_o & ~mem_d_oe_o) == 2'h0)
      else $error("write strobe on undriven lane");
   a_rd_wr_apart: assert property (
      !mem_rd_n_o |-> mem_wr_n_o == 2'h3 && mem_d_oe_o == 2'h0)
      else $error("lane driven during read");
   a_high_lane_addr: assert property (
      !mem_wr_n_o[1] |-> mem_addr_o[0] == mem_wr_n_o[0])
      else $error("high lane byte at wrong address");
   a_ack_single: assert property (
      $rose(cpu_ack_o) |-> !cpu_ready_o ##1 !cpu_ack_o)
      else $error("operand ack not a single pulse");
   a_hold_in_beat: assert property (
      !mem_rd_n_o && !$past(mem_rd_n_o) |->
      $stable(mem_cs_n_o) && $stable(mem_addr_o))
      else $error("chip select changed inside read beat");
endmodule

/* File: bench/ext_mem_model.sv */
// external memory and wait pin model facing the bus sizer
`timescale 1ns/100ps
module ext_mem_model (
   input wire clk_i,
   input wire wide_i,
   input wire [3:0] stall_i,
   input wire [23:0] addr_i,
   input wire rd_n_i,
   input wire [1:0] wr_n_i,
   input wire [15:0] d_i,
   output logic [15:0] d_o,
   output logic wait_n_o
);
   logic [7:0] mem [0:255];
   logic [15:0] last_q;
   logic [3:0] stall_q;
   logic busy_q;
   wire [7:0] lo_a = wide_i ? {addr_i[7:1], 1'b0} : addr_i[7:0];
   wire [7:0] hi_a = {addr_i[7:1], 1'b1};
   wire act = !rd_n_i || wr_n_i != 2'h3;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'h00;
      last_q = 16'h0000;
      stall_q = 4'h0;
      busy_q = 1'b0;
   end
   // only lanes with an active strobe are stored
   always @(posedge clk_i) begin
      if (!wr_n_i[0]) mem[lo_a] <= d_i[7:0];
      if (!wr_n_i[1]) mem[hi_a] <= d_i[15:8];
      if (!rd_n_i) last_q <= d_o;
      busy_q <= act;
      if (act && !busy_q) stall_q <= stall_i;
      else if (stall_q != 4'h0) stall_q <= stall_q - 4'h1;
   end
   // released bus shows inverted old data so stale values never match
   always @* d_o = rd_n_i ? ~last_q : {mem[hi_a], mem[lo_a]};
   // a busy device keeps wait low before the beat and for one cycle
   // more than the asked count into it; the sizer sees the pin two cycles late
   always @* wait_n_o = (stall_i == 4'h0) || (busy_q && stall_q == 4'h0);
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the bus sizer
`timescale 1ns/100ps
`include "bus_sizer_regs.vh"
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [9:0] wb_adr_i = 10'h000;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, cpu_wdata_i = 32'h0;
   logic cpu_req_i = 1'b0, cpu_we_i = 1'b0, internal_hit_i = 1'b0;
   logic [1:0] cpu_size_i = 2'h0;
   logic [23:0] cpu_addr_i = 24'h0;
   logic [3:0] area_hit_i = 4'h0, stall = 4'h0, cs_seen = 4'h0;
   logic mem_wide = 1'b1, mem_wait_n_i;
   logic [15:0] mem_d_i;
   wire [31:0] wb_dat_o, cpu_rdata_o;
   wire wb_ack_o, cpu_ready_o, cpu_ack_o, mem_rd_n_o;
   wire [23:0] mem_addr_o;
   wire [3:0] mem_cs_n_o;
   wire [1:0] mem_wr_n_o, mem_d_oe_o;
   wire [15:0] mem_d_o;
   int bad_count = 0, num_checks = 0, cyc = 0;
   int cs_cyc = 0, lo_cyc = 0, hi_cyc = 0;
   bus_sizer #(.ADDR_W(24)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_req_i(cpu_req_i),
      .cpu_we_i(cpu_we_i), .cpu_size_i(cpu_size_i), .cpu_addr_i(cpu_addr_i),
      .cpu_wdata_i(cpu_wdata_i), .area_hit_i(area_hit_i),
      .internal_hit_i(internal_hit_i), .cpu_ready_o(cpu_ready_o),
      .cpu_ack_o(cpu_ack_o), .cpu_rdata_o(cpu_rdata_o),
      .mem_addr_o(mem_addr_o), .mem_cs_n_o(mem_cs_n_o),
      .mem_rd_n_o(mem_rd_n_o), .mem_wr_n_o(mem_wr_n_o), .mem_d_i(mem_d_i),
      .mem_d_o(mem_d_o), .mem_d_oe_o(mem_d_oe_o),
      .mem_wait_n_i(mem_wait_n_i));
   ext_mem_model far_end (.clk_i(clk_i), .wide_i(mem_wide), .stall_i(stall),
      .addr_i(mem_addr_o), .rd_n_i(mem_rd_n_o), .wr_n_i(mem_wr_n_o),
      .d_i(mem_d_o), .d_o(mem_d_i), .wait_n_o(mem_wait_n_i));
   always #10 clk_i = ~clk_i;
   // pin activity counters, cleared by each operand
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (mem_cs_n_o != 4'hF) cs_cyc <= cs_cyc + 1;
      if (mem_cs_n_o != 4'hF) cs_seen <= cs_seen | ~mem_cs_n_o;
      if (!mem_wr_n_o[0]) lo_cyc <= lo_cyc + 1;
      if (!mem_wr_n_o[1]) hi_cyc <= hi_cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one classic cycle; waits for ack, never assumes its delay
   task automatic wb(input logic we, input logic [7:0] idx,
      input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'h0};
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 50) chk(1'b0, 1'b1);
   endtask
   // one operand; request held until the edge that takes it
   task automatic op(input logic we, input logic [1:0] sz,
      input logic [23:0] a, input logic [31:0] wd, input logic [3:0] hit,
      input logic ih, output logic [31:0] q);
      int n = 0;
      @(posedge clk_i);
      {cpu_req_i, cpu_we_i, cpu_size_i, cpu_addr_i} <= {1'b1, we, sz, a};
      {cpu_wdata_i, area_hit_i, internal_hit_i} <= {wd, hit, ih};
      {cs_cyc, lo_cyc, hi_cyc, cs_seen} <= {32'h0, 32'h0, 32'h0, 4'h0};
      do @(posedge clk_i); while (cpu_ready_o !== 1'b1 && ++n < 50);
      cpu_req_i <= 1'b0;
      do @(posedge clk_i); while (cpu_ack_o !== 1'b1 && ++n < 200);
      q = cpu_rdata_o;
      if (n >= 200) chk(1'b0, 1'b1);
   endtask
   task automatic t_regs;
      logic [31:0] q;
      for (int i = 0; i < 4; i++) begin
         wb(1'b0, `IDX_AREA0_CTL + i[7:0], 32'h0, q);
         chk(q, i == 2 ? 32'h80 : 32'h0);
      end
      wb(1'b0, `IDX_FALLBACK_CTL, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b1, 8'h10, 32'hFF, q);
      wb(1'b0, 8'h10, 32'h0, q);
      chk(q, 32'h0);
      op(1'b0, `SIZE_BYTE, 24'h002000, 32'h0, 4'h0, 1'b0, q);
      chk(cs_seen, 4'h4);
      chk(cs_cyc, 32'h3);
      wb(1'b0, `IDX_SIZER_STATUS, 32'h0, q);
      chk(q, 32'h8);
      $display("test regs done");
   endtask
   task automatic t_waits;
      logic [31:0] q;
      logic [2:0] code [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
      int w [6] = '{2, 1, 0, 3, 4, 8};
      stall <= 4'h6;
      for (int i = 0; i < 6; i++) begin
         wb(1'b1, `IDX_AREA0_CTL, {24'h0, 5'h10, code[i]}, q);
         op(1'b0, `SIZE_BYTE, 24'h000100, 32'h0, 4'h1, 1'b0, q);
         chk(cs_cyc, w[i] + 1);
         chk(cs_seen, 4'h1);
      end
      wb(1'b1, `IDX_AREA0_CTL, 32'h82, q);
      stall <= 4'h0;
      op(1'b0, `SIZE_BYTE, 24'h000100, 32'h0, 4'h1, 1'b0, q);
      chk(cs_cyc, 32'h2);
      stall <= 4'h6;
      op(1'b0, `SIZE_BYTE, 24'h000100, 32'h0, 4'h1, 1'b0, q);
      // pin low seven cycles into the beat, two synchroniser cycles, last TW, T2
      chk(cs_cyc, 32'hB);
      $display("test waits done");
   endtask
   task automatic t_sizing;
      logic [31:0] q;
      stall <= 4'h0;
      wb(1'b1, `IDX_AREA0_CTL, 32'hB3, q);
      op(1'b1, `SIZE_LONG, 24'h000101, 32'hA1B2C3D4, 4'h1, 1'b0, q);
      chk({lo_cyc[15:0], hi_cyc[15:0]}, 32'h20002);
      op(1'b0, `SIZE_LONG, 24'h000101, 32'h0, 4'h1, 1'b0, q);
      chk(q, 32'hA1B2C3D4);
      op(1'b1, `SIZE_BYTE, 24'h000121, 32'h77, 4'h1, 1'b0, q);
      chk({lo_cyc[15:0], hi_cyc[15:0]}, 32'h1);
      wb(1'b1, `IDX_AREA0_CTL, 32'h8B, q);
      mem_wide <= 1'b0;
      op(1'b1, `SIZE_LONG, 24'h000110, 32'h5A6B7C8D, 4'h1, 1'b0, q);
      chk({lo_cyc[15:0], hi_cyc[15:0]}, 32'h40000);
      op(1'b0, `SIZE_LONG, 24'h000110, 32'h0, 4'h1, 1'b0, q);
      chk(q, 32'h5A6B7C8D);
      $display("test sizing done");
   endtask
   task automatic t_fallback;
      logic [31:0] q;
      wb(1'b1, `IDX_AREA0_CTL, 32'h03, q);
      wb(1'b1, `IDX_FALLBACK_CTL, 32'h0B, q);
      op(1'b1, `SIZE_WORD, 24'h000140, 32'hBEEF, 4'h1, 1'b0, q);
      chk(cs_seen, 4'h0);
      chk({lo_cyc[15:0], hi_cyc[15:0]}, 32'h20000);
      op(1'b0, `SIZE_WORD, 24'h000140, 32'h0, 4'h1, 1'b0, q);
      chk({16'h0, q[15:0]}, 32'hBEEF);
      wb(1'b1, `IDX_AREA0_CTL, 32'h83, q);
      op(1'b0, `SIZE_BYTE, 24'h000100, 32'h0, 4'h1, 1'b1, q);
      chk({cs_seen, q[27:0]}, 32'h0);
      $display("test fallback done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_waits();
      t_sizing();
      t_fallback();
      summarize();
   end
endmodule
bind bus_sizer bus_sizer_chk #(.ADDR_W(ADDR_W)) chk (.clk_i(clk_i),
   .rst_i(rst_i), .cpu_req_i(cpu_req_i), .internal_hit_i(internal_hit_i),
   .cpu_ready_o(cpu_ready_o), .cpu_ack_o(cpu_ack_o),
   .mem_addr_o(mem_addr_o), .mem_cs_n_o(mem_cs_n_o),
   .mem_rd_n_o(mem_rd_n_o), .mem_wr_n_o(mem_wr_n_o),
   .mem_d_oe_o(mem_d_oe_o));
